// ### hdl/hpm_pkg.sv
// Constants and types for the multiplexed host port pin-role block
package hpm_pkg;
  localparam int PORT_W = 32;
  localparam int DATA_W = 16;
  localparam logic [3:0] FS_PARALLEL = 4'h0;
  localparam logic [3:0] FS_SERIAL = 4'h1;
  localparam int PIN_SEL_WIDTH = 0;
  localparam int PIN_SCLK_RD = 1;
  localparam int PIN_SDIO_WR = 2;
  localparam int PIN_SDO = 3;
  localparam int PIN_RESYNC = 4;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_MSB = 15;
  localparam int DATA_LSB = 16;
  localparam int DATA_MSB = 31;
  localparam int DATA8_MSB = 23;
  localparam logic [4:0] SER_INSTR_LAST = 5'h07;
  localparam logic [4:0] SER_WORD_LAST = 5'h17;
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [PORT_W-1:0] PORT_RST = 32'h0000_0000;
  localparam logic [4:0] CNT_RST = 5'h00;

  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'b00,
    MODE_SERIAL = 2'b01,
    MODE_MODULATION = 2'b10
  } hpm_mode_e;

  typedef enum logic [1:0] {
    LS_INSTR = 2'b00,
    LS_WDATA = 2'b01,
    LS_RDATA = 2'b10,
    LS_DONE = 2'b11
  } hpm_lstate_e;
endpackage : hpm_pkg

// ### hdl/hpm_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module hpm_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } hpm_sync_s;

  hpm_sync_s st_ff;
  hpm_sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
    if (!i_rst_n) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  assign o_q = st_ff.s2;
endmodule : hpm_sync2

// ### hdl/hpm_host_port.sv
// Host port pin-role mux with serial and parallel register access
`timescale 1ns/10ps
module hpm_host_port
  import hpm_pkg::*;
#(
  parameter int REG_COUNT = 16,
  parameter bit SDIO_READBACK = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_clk,
  input wire logic [3:0] i_function_select_inputs,
  input wire logic [PORT_W-1:0] i_port_pins,
  output logic [PORT_W-1:0] o_port_out,
  output logic [PORT_W-1:0] o_port_oe,
  output logic o_serial_readback_out,
  output logic o_serial_readback_oe,
  output logic o_serial_io_out,
  output logic o_serial_io_oe,
  output logic [PORT_W-1:0] o_mod_word,
  output logic [1:0] o_mode,
  output logic [REG_COUNT*DATA_W-1:0] o_reg_bank
);
  localparam int IDX_W = $clog2(REG_COUNT);

  typedef struct packed {
    hpm_mode_e mode;
    logic wr_prev;
    logic tgl_prev;
    logic [REG_COUNT-1:0][DATA_W-1:0] bank;
    logic [PORT_W-1:0] port_out;
    logic [PORT_W-1:0] port_oe;
    logic [PORT_W-1:0] mod_word;
  } hpm_core_s;

  // Frame state, cleared whenever the frame ends
  typedef struct packed {
    hpm_lstate_e state;
    logic [4:0] cnt;
    logic [DATA_W-1:0] shreg;
    logic sdo;
    logic sdo_oe;
    logic sdio_oe;
  } hpm_frame_s;

  // Write hand-off, survives between frames
  typedef struct packed {
    logic [7:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_tgl;
  } hpm_xfer_s;

  hpm_core_s core_ff;
  hpm_core_s nxt_core;
  hpm_frame_s frm_ff;
  hpm_frame_s nxt_frm;
  hpm_xfer_s xf_ff;
  hpm_xfer_s nxt_xf;

  logic [3:0] fs_s;
  logic [PORT_W-1:0] pins_s;
  logic tgl_s;
  logic ser_mode_s;
  logic link_clr;
  logic sdio_in;
  logic [7:0] p_addr;
  logic [7:0] s_addr;
  logic [DATA_W-1:0] p_rdata;
  logic [DATA_W-1:0] s_rdata;

  hpm_sync2 #(.WIDTH(4)) u_fs_sync (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_function_select_inputs),
    .o_q(fs_s)
  );

  hpm_sync2 #(.WIDTH(PORT_W)) u_pin_sync (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d(i_port_pins),
    .o_q(pins_s)
  );

  hpm_sync2 #(.WIDTH(1)) u_tgl_sync (
    .i_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_d(xf_ff.wr_tgl),
    .o_q(tgl_s)
  );

  hpm_sync2 #(.WIDTH(1)) u_mode_sync (
    .i_clk(i_serial_clk),
    .i_rst_n(i_rst_n),
    .i_d(core_ff.mode == MODE_SERIAL),
    .o_q(ser_mode_s)
  );

  // Register lookup shared by both access paths
  function automatic logic [DATA_W-1:0] reg_read(
    input logic [REG_COUNT-1:0][DATA_W-1:0] bank,
    input logic [7:0] addr
  );
    logic [DATA_W-1:0] val;
    val = REG_RST;
    if (32'(addr) < REG_COUNT) begin
      val = bank[addr[IDX_W-1:0]];
    end
    return val;
  endfunction : reg_read

  assign p_addr = pins_s[ADDR_MSB:ADDR_LSB];
  assign p_rdata = reg_read(core_ff.bank, p_addr);

  // Core domain: role decode, parallel access, serial write apply
  always_comb begin
    nxt_core = core_ff;
    nxt_core.wr_prev = pins_s[PIN_SDIO_WR];
    nxt_core.tgl_prev = tgl_s;
    nxt_core.port_out = PORT_RST;
    nxt_core.port_oe = PORT_RST;
    if (fs_s == FS_PARALLEL) begin
      nxt_core.mode = MODE_PARALLEL;
    end else if (fs_s == FS_SERIAL) begin
      nxt_core.mode = MODE_SERIAL;
    end else begin
      nxt_core.mode = MODE_MODULATION;
    end
    // Act on the fresh decode so no stale pin word leaks past a mode change
    case (nxt_core.mode)
      MODE_PARALLEL: begin
        if (pins_s[PIN_SDIO_WR] && !core_ff.wr_prev &&
            32'(p_addr) < REG_COUNT) begin
          if (pins_s[PIN_SEL_WIDTH]) begin
            nxt_core.bank[p_addr[IDX_W-1:0]] =
              pins_s[DATA_MSB:DATA_LSB];
          end else begin
            nxt_core.bank[p_addr[IDX_W-1:0]][7:0] =
              pins_s[DATA8_MSB:DATA_LSB];
          end
        end
        if (pins_s[PIN_SCLK_RD]) begin
          nxt_core.port_out[DATA_MSB:DATA_LSB] = p_rdata;
          if (pins_s[PIN_SEL_WIDTH]) begin
            nxt_core.port_oe[DATA_MSB:DATA_LSB] = '1;
          end else begin
            nxt_core.port_oe[DATA8_MSB:DATA_LSB] = '1;
          end
        end
      end
      MODE_SERIAL: begin
        // Address and data are held stable long before the toggle lands
        if (tgl_s != core_ff.tgl_prev &&
            32'(xf_ff.wr_addr) < REG_COUNT) begin
          nxt_core.bank[xf_ff.wr_addr[IDX_W-1:0]] = xf_ff.wr_data;
        end
      end
      default: begin
        nxt_core.mod_word = pins_s;
      end
    endcase
    if (!i_rst_n) begin
      nxt_core.mode = MODE_MODULATION;
      nxt_core.wr_prev = 1'b0;
      nxt_core.tgl_prev = 1'b0;
      nxt_core.port_out = PORT_RST;
      nxt_core.port_oe = PORT_RST;
      nxt_core.mod_word = PORT_RST;
      for (int i = 0; i < REG_COUNT; i++) begin
        nxt_core.bank[i] = REG_RST;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    core_ff <= nxt_core;
  end

  // Serial side runs on the host's clock; pins are in its domain
  assign sdio_in = i_port_pins[PIN_SDIO_WR];
  // Frame ends on chip select high or resync; clock may stop afterwards
  assign link_clr = !i_rst_n || i_port_pins[PIN_SEL_WIDTH] ||
    i_port_pins[PIN_RESYNC];
  assign s_addr = {1'b0, frm_ff.shreg[5:0], sdio_in};
  // Bank is quasi-static here: serial writes land many edges ahead
  assign s_rdata = reg_read(core_ff.bank, s_addr);

  always_comb begin
    nxt_frm = frm_ff;
    nxt_xf = xf_ff;
    nxt_frm.sdo_oe = ser_mode_s;
    nxt_frm.cnt = frm_ff.cnt + 5'h01;
    case (frm_ff.state)
      LS_INSTR: begin
        nxt_frm.shreg = {frm_ff.shreg[DATA_W-2:0], sdio_in};
        if (frm_ff.cnt == SER_INSTR_LAST) begin
          if (frm_ff.shreg[6]) begin
            nxt_frm.state = LS_RDATA;
            nxt_frm.shreg = s_rdata;
            nxt_frm.sdo = s_rdata[DATA_W-1];
            nxt_frm.sdio_oe = SDIO_READBACK && ser_mode_s;
          end else begin
            nxt_frm.state = LS_WDATA;
            nxt_xf.wr_addr = s_addr;
          end
        end
      end
      LS_WDATA: begin
        nxt_frm.shreg = {frm_ff.shreg[DATA_W-2:0], sdio_in};
        if (frm_ff.cnt == SER_WORD_LAST) begin
          nxt_frm.state = LS_DONE;
          nxt_xf.wr_data = {frm_ff.shreg[DATA_W-2:0], sdio_in};
          nxt_xf.wr_tgl = !xf_ff.wr_tgl;
        end
      end
      LS_RDATA: begin
        nxt_frm.shreg = {frm_ff.shreg[DATA_W-2:0], 1'b0};
        nxt_frm.sdo = frm_ff.shreg[DATA_W-2];
        if (frm_ff.cnt == SER_WORD_LAST) begin
          nxt_frm.state = LS_DONE;
          nxt_frm.sdio_oe = 1'b0;
        end
      end
      default: begin
        nxt_frm.cnt = frm_ff.cnt;
      end
    endcase
  end

  always_ff @(posedge i_serial_clk or posedge link_clr) begin
    if (link_clr) begin
      frm_ff.state <= LS_INSTR;
      frm_ff.cnt <= CNT_RST;
      frm_ff.shreg <= REG_RST;
      frm_ff.sdo <= 1'b0;
      frm_ff.sdo_oe <= 1'b0;
      frm_ff.sdio_oe <= 1'b0;
    end else begin
      frm_ff <= nxt_frm;
    end
  end

  always_ff @(posedge i_serial_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xf_ff.wr_addr <= 8'h00;
      xf_ff.wr_data <= REG_RST;
      xf_ff.wr_tgl <= 1'b0;
    end else begin
      xf_ff <= nxt_xf;
    end
  end

  assign o_port_out = core_ff.port_out;
  assign o_port_oe = core_ff.port_oe;
  assign o_mod_word = core_ff.mod_word;
  assign o_mode = core_ff.mode;
  assign o_reg_bank = core_ff.bank;
  assign o_serial_readback_out = frm_ff.sdo;
  assign o_serial_readback_oe = frm_ff.sdo_oe;
  assign o_serial_io_out = frm_ff.sdo;
  assign o_serial_io_oe = frm_ff.sdio_oe;
endmodule : hpm_host_port

// ### testbench/hpm_host_port_monitor.sv
// Checker for host port pin roles
`timescale 1ns/10ps
module hpm_host_port_monitor
  import hpm_pkg::*;
#(parameter int REG_COUNT = 16) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_function_select_inputs,
  input wire logic [31:0] i_port_pins,
  input wire logic [31:0] o_port_oe,
  input wire logic o_serial_readback_oe,
  input wire logic o_serial_io_oe,
  input wire logic [31:0] o_mod_word,
  input wire logic [1:0] o_mode,
  input wire logic [REG_COUNT*16-1:0] o_reg_bank
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_sel;
    (i_function_select_inputs == FS_SERIAL) [*5] |-> o_mode == MODE_SERIAL;
  endproperty
  a_sel: assert property (p_sel) else $error("mode");
  property p_mod;
    (o_mode == MODE_MODULATION) [*5] |-> o_mod_word == $past(i_port_pins, 3);
  endproperty
  a_mod: assert property (p_mod) else $error("mod word");
  property p_wr;
    o_mode == MODE_PARALLEL && $rose(i_port_pins[2]) && i_port_pins[0] &&
      i_port_pins[15:12] == 4'h0 |-> ##[2:5]
      o_reg_bank[{i_port_pins[11:8], 4'h0} +: 16] == i_port_pins[31:16];
  endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_rd16;
    (o_mode == MODE_PARALLEL && i_port_pins[1:0] == 2'h3) [*6] |->
      o_port_oe == 32'hffff_0000;
  endproperty
  a_rd16: assert property (p_rd16) else $error("read oe");
  property p_rd8;
    (o_mode == MODE_PARALLEL && i_port_pins[1:0] == 2'h2) [*6] |->
      o_port_oe == 32'h00ff_0000;
  endproperty
  a_rd8: assert property (p_rd8) else $error("read8 oe");
  property p_off;
    (!i_port_pins[1] || o_mode != MODE_PARALLEL) [*6] |-> o_port_oe == '0;
  endproperty
  a_off: assert property (p_off) else $error("port oe");
  property p_sdo;
    (o_mode != MODE_SERIAL) [*5] |-> !o_serial_readback_oe;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sdo oe");
  property p_resync;
    $past(i_port_pins[4]) && i_port_pins[4] |-> !o_serial_io_oe;
  endproperty
  a_resync: assert property (p_resync) else $error("resync");
endmodule : hpm_host_port_monitor
bind hpm_host_port hpm_host_port_monitor #(.REG_COUNT(REG_COUNT))
  hpm_host_port_monitor_inst (.i_core_clk, .i_rst_n,
  .i_function_select_inputs, .i_port_pins, .o_port_oe, .o_mod_word,
  .o_serial_readback_oe, .o_serial_io_oe, .o_mode, .o_reg_bank);

// ### testbench/hpm_host_model.sv
// Host model driving serial frames
`timescale 1ns/10ps
module hpm_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdio,
  input wire logic i_sdo,
  input wire logic i_sdio
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdio = 1'b0;
  end
  // Instruction byte then data word, MSB first
  task automatic frame(input logic [23:0] bits, output logic [15:0] rd,
    output logic [15:0] rd_io);
    rd = 16'h0;
    rd_io = 16'h0;
    o_cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      o_sdio = bits[23-i];
      #32;
      // Sample before the edge that replaces the bit
      if (i > 7) rd = {rd[14:0], i_sdo};
      if (i > 7) rd_io = {rd_io[14:0], i_sdio};
      o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    #32 o_cs_n = 1'b1;
    o_sdio = ~o_sdio;
    // Chip select stays high between frames
    #64;
  endtask : frame
endmodule : hpm_host_model

// ### testbench/hpm_host_port_tb.sv
// Bench for host port pin roles
`timescale 1ns/10ps
module hpm_host_port_tb;
  typedef struct packed {
    logic [3:0] sel;
    logic [31:0] pins;
    logic [1:0] mode;
    logic [31:0] oe;
    logic [31:0] word;
  } hpm_row_s;
  hpm_row_s rows [5] = '{
    '{4'h2, 32'h1234_5678, 2'h2, 32'h0, 32'h1234_5678},
    '{4'hf, 32'h8765_4321, 2'h2, 32'h0, 32'h8765_4321},
    '{4'h1, 32'h0000_0001, 2'h1, 32'h0, 32'h8765_4321},
    '{4'h0, 32'h0000_0003, 2'h0, 32'hffff_0000, 32'h8765_4321},
    '{4'h0, 32'h0000_0002, 2'h0, 32'h00ff_0000, 32'h8765_4321}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ser = 1'b0;
  logic [3:0] sel = 4'h2;
  logic [31:0] pins = 32'h0;
  logic [15:0] rd;
  logic [15:0] rd_io;
  int miscompares = 0;
  int check_count = 0;
  wire sclk, cs_n, h_sdio, ro_out, ro_oe, io_out, io_oe;
  wire [31:0] pout, poe, word, pad, pin;
  wire [1:0] mode;
  wire [255:0] bank;
  wire pin2 = io_oe ? io_out : (ser ? h_sdio : pad[2]);
  wire pin3 = ro_oe ? ro_out : pad[3];
  assign pad = (poe & pout) | (~poe & pins);
  assign pin = {pad[31:4], pin3, pin2, ser ? {sclk, cs_n} : pad[1:0]};
  hpm_host_port hpm_host_port_inst (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_serial_clk(sclk), .i_function_select_inputs(sel), .i_port_pins(pin),
    .o_port_out(pout), .o_port_oe(poe), .o_serial_readback_out(ro_out),
    .o_serial_readback_oe(ro_oe), .o_serial_io_out(io_out),
    .o_serial_io_oe(io_oe), .o_mod_word(word), .o_mode(mode),
    .o_reg_bank(bank));
  hpm_host_model hpm_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdio(h_sdio), .i_sdo(pin3), .i_sdio(pin2));
  always #12.5 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic results;
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic pwr(input logic [7:0] a, input logic [15:0] d, input logic w);
    pins <= {d, a, 7'h00, w};
    cyc(4);
    pins[2] <= 1'b1;
    cyc(4);
    pins[2] <= 1'b0;
    cyc(8);
  endtask : pwr
  initial begin
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    foreach (rows[i]) begin
      sel <= rows[i].sel;
      pins <= rows[i].pins;
      cyc(10);
      chk("mode", {30'h0, rows[i].mode}, {30'h0, mode});
      chk("oe", rows[i].oe, poe);
      chk("word", rows[i].word, word);
    end
    pwr(8'h03, 16'ha5c3, 1'b1);
    pwr(8'h13, 16'h0f0f, 1'b1);
    pwr(8'h05, 16'h77e1, 1'b0);
    chk("bank3", 32'ha5c3, {16'h0, bank[48 +: 16]});
    chk("bank5", 32'h00e1, {16'h0, bank[80 +: 16]});
    pins <= 32'h0000_0303;
    cyc(8);
    chk("rdata", 32'ha5c3, {16'h0, pin[31:16]});
    pins <= 32'h0;
    sel <= 4'h1;
    ser <= 1'b1;
    cyc(8);
    hpm_host_model_inst.frame({8'h06, 16'hbeef}, rd, rd_io);
    cyc(8);
    chk("ser wr", 32'hbeef, {16'h0, bank[96 +: 16]});
    hpm_host_model_inst.frame({8'h86, 16'h0}, rd, rd_io);
    chk("ser rd", 32'hbeef, {16'h0, rd});
    chk("ser io rd", 32'hbeef, {16'h0, rd_io});
    cyc(1);
    pins[4] <= 1'b1;
    cyc(2);
    hpm_host_model_inst.frame({8'h07, 16'h1111}, rd, rd_io);
    hpm_host_model_inst.frame({8'h86, 16'h0}, rd, rd_io);
    chk("resync rd", 32'h0, {16'h0, rd});
    cyc(8);
    chk("resync", 32'h0, {16'h0, bank[112 +: 16]});
    rst_n <= 1'b0;
    cyc(6);
    chk("rst bank", 32'h0, {16'h0, bank[96 +: 16]});
    chk("rst mode", 32'h2, {30'h0, mode});
    results();
  end
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule : hpm_host_port_tb
